// *** tb/bridge_config_ctrl_regs_tb.sv ***
`timescale 1ns/1ps
module bridge_config_ctrl_regs_tb;
  logic clk, rst, rd, wr, rvalid, io_en, mem_en, drv_en;
  logic [7:0] addr;
  logic [3:0] be_n;
  logic [31:0] wdata, rdata, io_base, io_limit, p_addr, s_addr;
  logic p_io, p_mem, p_claim, s_io, s_mem, s_claim;
  logic dp, ap, mst, s_serr_n, perr_n, perr_oe, dpar, serr_n, serr_oe;
  int fail_count = 0;
  int check_count = 0;

  // ----------------------------------------
  // design and secondary agent
  // ----------------------------------------
  bridge_config_ctrl_regs u_bridge_config_ctrl_regs (
    .core_clk_i(clk), .reset_i(rst), .cfg_read_i(rd), .cfg_write_i(wr),
    .cfg_addr_i(addr), .cfg_byte_en_n_i(be_n), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .io_space_en_i(io_en),
    .mem_space_en_i(mem_en), .serr_drv_en_i(drv_en), .io_base_i(io_base),
    .io_limit_i(io_limit), .pri_addr_i(p_addr), .pri_io_i(p_io), .pri_mem_i(p_mem),
    .pri_claim_o(p_claim), .sec_addr_i(s_addr), .sec_io_i(s_io), .sec_mem_i(s_mem),
    .sec_claim_o(s_claim), .sec_data_perr_i(dp), .sec_addr_perr_i(ap),
    .sec_bridge_master_i(mst), .sec_serr_n_i(s_serr_n), .sec_perr_n_o(perr_n),
    .sec_perr_oe_o(perr_oe), .dpar_reported_set_o(dpar), .pri_serr_n_o(serr_n),
    .pri_serr_oe_o(serr_oe));

  sec_agent_model u_sec_agent_model (
    .clk_i(clk), .data_perr_o(dp), .addr_perr_o(ap), .master_o(mst),
    .serr_n_o(s_serr_n));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // write is taken at the second edge and dropped there
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] ben, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    be_n <= ben;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  // answer stands 1ns after the taking edge
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    be_n <= 4'h0;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    check({31'h0, rvalid}, 32'h1);
    check(rdata, exp);
  endtask

  task automatic set_ctl(input logic [3:0] v);
    cfg_wr(8'h3e, 4'hb, {12'h0, v, 16'h0});
  endtask

  // claims are combinational, so both buses see the same request
  task automatic decode(input logic [31:0] a, input logic io, input logic mem,
                        input logic ep, input logic es);
    @(posedge clk);
    p_addr <= a;
    s_addr <= a;
    p_io <= io;
    s_io <= io;
    p_mem <= mem;
    s_mem <= mem;
    #1;
    check({30'h0, p_claim, s_claim}, {30'h0, ep, es});
  endtask

  task automatic err_chk(input logic ep, input logic ed, input logic es);
    #1;
    check({27'h0, perr_oe, perr_n, dpar, serr_oe, serr_n}, {27'h0, ep, ~ep, ed, es, ~es});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs;
    cfg_rd(8'h34, 32'h0000_00dc);
    cfg_rd(8'h3c, 32'h0000_0000);
    cfg_wr(8'h34, 4'h0, 32'hffff_ffff);
    cfg_rd(8'h34, 32'hffff_00dc);
    cfg_wr(8'h36, 4'h7, 32'h1234_5678);
    cfg_rd(8'h34, 32'h12ff_00dc);
    cfg_wr(8'h34, 4'hc, 32'h0000_0000);
    cfg_rd(8'h34, 32'h12ff_00dc);
    cfg_wr(8'h3c, 4'h0, 32'hffff_ffff);
    cfg_rd(8'h3c, 32'h000f_0000);
    cfg_wr(8'h3c, 4'hf, 32'h0000_0000);
    cfg_rd(8'h3c, 32'h000f_0000);
    cfg_wr(8'h40, 4'h0, 32'hffff_ffff);
    cfg_rd(8'h40, 32'h0000_0000);
    // mid-run reset must clear the identifier and control bits
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    cfg_rd(8'h34, 32'h0000_00dc);
    cfg_rd(8'h3c, 32'h0000_0000);
  endtask

  task automatic test_errors;
    u_sec_agent_model.inject(1'h1, 1'h0, 1'h0, 1'h1);
    err_chk(1'h0, 1'h0, 1'h0);
    u_sec_agent_model.inject(1'h0, 1'h1, 1'h0, 1'h0);
    err_chk(1'h0, 1'h0, 1'h0);
    u_sec_agent_model.inject(1'h0, 1'h0, 1'h1, 1'h0);
    err_chk(1'h0, 1'h0, 1'h0);
    set_ctl(4'h1);
    u_sec_agent_model.inject(1'h1, 1'h0, 1'h0, 1'h1);
    err_chk(1'h1, 1'h1, 1'h0);
    // error on a transfer the bridge did not master: perr only, no status
    u_sec_agent_model.inject(1'h1, 1'h0, 1'h0, 1'h0);
    err_chk(1'h1, 1'h0, 1'h0);
    u_sec_agent_model.inject(1'h0, 1'h1, 1'h0, 1'h0);
    err_chk(1'h0, 1'h0, 1'h1);
    set_ctl(4'h2);
    u_sec_agent_model.inject(1'h0, 1'h0, 1'h1, 1'h0);
    err_chk(1'h0, 1'h0, 1'h1);
    @(posedge clk);
    drv_en <= 1'h0;
    u_sec_agent_model.inject(1'h0, 1'h0, 1'h1, 1'h0);
    err_chk(1'h0, 1'h0, 1'h0);
  endtask

  task automatic test_isa;
    set_ctl(4'h0);
    decode(32'h0000_0100, 1'h1, 1'h0, 1'h1, 1'h0);
    decode(32'h0003_0100, 1'h1, 1'h0, 1'h0, 1'h1);
    set_ctl(4'h4);
    decode(32'h0000_0100, 1'h1, 1'h0, 1'h0, 1'h1);
    decode(32'h0000_0050, 1'h1, 1'h0, 1'h1, 1'h0);
    decode(32'h0001_0100, 1'h1, 1'h0, 1'h1, 1'h1);
    decode(32'h0000_fbff, 1'h1, 1'h0, 1'h0, 1'h1);
  endtask

  task automatic test_vga;
    decode(32'h0000_03c0, 1'h1, 1'h0, 1'h0, 1'h1);
    decode(32'h000a_0000, 1'h0, 1'h1, 1'h0, 1'h1);
    set_ctl(4'h0);
    decode(32'h0000_03c0, 1'h1, 1'h0, 1'h1, 1'h0);
    set_ctl(4'hc);
    cfg_rd(8'h3c, 32'h000c_0000);
    decode(32'h000a_0000, 1'h0, 1'h1, 1'h1, 1'h0);
    decode(32'h000b_ffff, 1'h0, 1'h1, 1'h1, 1'h0);
    decode(32'h0009_ffff, 1'h0, 1'h1, 1'h0, 1'h1);
    decode(32'h000c_0000, 1'h0, 1'h1, 1'h0, 1'h1);
    decode(32'h0000_03bb, 1'h1, 1'h0, 1'h1, 1'h0);
    decode(32'h0000_03bc, 1'h1, 1'h0, 1'h0, 1'h1);
    decode(32'h0000_fbdf, 1'h1, 1'h0, 1'h1, 1'h0);
    decode(32'h0002_03c0, 1'h1, 1'h0, 1'h0, 1'h1);
    // software-side enables off: vga claims must drop
    @(posedge clk);
    io_en <= 1'h0;
    mem_en <= 1'h0;
    decode(32'h0000_03c0, 1'h1, 1'h0, 1'h0, 1'h0);
    decode(32'h000a_0000, 1'h0, 1'h1, 1'h0, 1'h0);
  endtask

  // ----------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------
  initial
    clk = 1'h0;
  always #50 clk = ~clk;

  initial
  begin
    rst = 1'h1;
    rd = 1'h0;
    wr = 1'h0;
    addr = 8'h00;
    be_n = 4'hf;
    wdata = 32'h0;
    io_en = 1'h1;
    mem_en = 1'h1;
    drv_en = 1'h1;
    io_base = 32'h0000_0000;
    io_limit = 32'h0001_ffff;
    p_addr = 32'h0;
    s_addr = 32'h0;
    {p_io, p_mem, s_io, s_mem} = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    test_regs;
    test_errors;
    test_isa;
    test_vga;
    report_and_stop;
  end

  // the sequence needs about 90 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
endmodule

// *** tb/sec_agent_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// secondary bus agent: error events only
// ----------------------------------------
module sec_agent_model
(
  input wire logic clk_i,
  output logic data_perr_o,
  output logic addr_perr_o,
  output logic master_o,
  output logic serr_n_o
);
  // idle bus: no errors, serr line at its pull-up level
  initial
  begin
    data_perr_o = 1'h0;
    addr_perr_o = 1'h0;
    master_o = 1'h0;
    serr_n_o = 1'h1;
  end

  // one-cycle event, dropped at the edge that samples it
  task automatic inject(input logic dp, input logic ap, input logic serr, input logic mst);
    @(posedge clk_i);
    data_perr_o <= dp;
    addr_perr_o <= ap;
    master_o <= mst;
    serr_n_o <= ~serr;
    @(posedge clk_i);
    data_perr_o <= 1'h0;
    addr_perr_o <= 1'h0;
    master_o <= 1'h0;
    serr_n_o <= 1'h1;
  endtask
endmodule

// *** verilog/bridge_addr_decode.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// per-bus address classifier, one copy per bus side
// ------------------------------------------------------------------
module bridge_addr_decode
  import bridge_cfg_pkg::*;
(
  input wire logic [31:0] addr_i,
  input wire logic [31:0] io_base_i,
  input wire logic [31:0] io_limit_i,
  input wire logic isa_mode_i,
  input wire logic vga_mode_i,
  output logic in_io_window_o,
  output logic isa_alias_o,
  output logic vga_io_o,
  output logic vga_mem_o
);

  // ----------------------------------------------------------------
  // address classes
  // ----------------------------------------------------------------
  wire logic low64k = (addr_i[31:16] == IO_LOW64K_HI);
  wire logic [9:0] low10 = addr_i[9:0];
  // bits 15:10 are left out on purpose: vga io aliases every 1KB
  wire logic vga_io_hit = ((low10 >= VGA_IO_A_LO) && (low10 <= VGA_IO_A_HI)) ||
                          ((low10 >= VGA_IO_B_LO) && (low10 <= VGA_IO_B_HI));
  wire logic vga_mem_hit = (addr_i >= VGA_MEM_LO) && (addr_i <= VGA_MEM_HI);

  assign in_io_window_o = (addr_i >= io_base_i) && (addr_i <= io_limit_i);
  // last 768 bytes of each 1KB block, only when isa mode is on
  assign isa_alias_o = isa_mode_i && (addr_i[9:8] != ISA_ALIAS_FREE);
  assign vga_io_o = vga_mode_i && low64k && vga_io_hit;
  assign vga_mem_o = vga_mode_i && vga_mem_hit;

endmodule

// *** verilog/bridge_cfg_pkg.sv ***
package bridge_cfg_pkg;

  // ----------------------------------------------------------------
  // configuration dword addresses (byte address of the aligned dword)
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_DWORD_ADDR = 8'h34; // pointer + subsystem identifier
  localparam logic [7:0] BRG_DWORD_ADDR = 8'h3c; // interrupt pin + bridge control
  localparam logic [7:0] CAP_PTR_OFFSET = 8'h34;
  localparam logic [7:0] SUBSYS_OFFSET = 8'h36;
  localparam logic [7:0] INT_PIN_OFFSET = 8'h3d;
  localparam logic [7:0] BRG_CTL_OFFSET = 8'h3e;

  // ----------------------------------------------------------------
  // fixed values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_PTR_VALUE = 8'hdc;
  localparam logic [7:0] INT_PIN_VALUE = 8'h00;
  localparam logic [15:0] SUBSYS_RESET = 16'h0000;
  localparam logic [3:0] BRG_CTL_RESET = 4'h0;

  // ----------------------------------------------------------------
  // bridge control field positions (within the 16-bit register)
  // ----------------------------------------------------------------
  localparam int BC_PERR_RESP = 0;
  localparam int BC_SERR_FWD = 1;
  localparam int BC_ISA_MODE = 2;
  localparam int BC_VGA_MODE = 3;
  localparam int BC_WIDTH = 4;

  // ----------------------------------------------------------------
  // address decode constants
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_LOW64K_HI = 16'h0000; // addr[31:16] of first 64KB
  localparam logic [9:0] VGA_IO_A_LO = 10'h3b0;
  localparam logic [9:0] VGA_IO_A_HI = 10'h3bb;
  localparam logic [9:0] VGA_IO_B_LO = 10'h3c0;
  localparam logic [9:0] VGA_IO_B_HI = 10'h3df;
  localparam logic [31:0] VGA_MEM_LO = 32'h000a0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000bffff;
  localparam logic [1:0] ISA_ALIAS_FREE = 2'h0; // addr[9:8] of the first 256 bytes

  // config access kinds
  typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} cfg_access_t;

endpackage

// *** verilog/bridge_config_ctrl_regs.sv ***
`timescale 1ns/1ps
// Contract
// - capability pointer reads constant dch
// - pointer dword bits 15:8 read zero
// - subsystem identifier writable, resets zero
// - interrupt pin byte always reads zero
// - parity response off blocks perr and status
// - parity response on drives perr, sets status for bridge-mastered transfers
// - address parity serr only with response on
// - forwarding off ignores secondary serr
// - forwarding and driver enable pass serr
// - isa off forwards whole io window
// - isa on drops low-64k alias addresses
// - isa on forwards alias addresses upstream
// - vga off follows window and isa
// - vga on claims vga memory range
// - vga on claims vga io ranges
// - vga ranges ignored on secondary bus
module bridge_config_ctrl_regs
  import bridge_cfg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  // configuration access
  input wire logic cfg_read_i,
  input wire logic cfg_write_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_byte_en_n_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // other configuration state
  input wire logic io_space_en_i,
  input wire logic mem_space_en_i,
  input wire logic serr_drv_en_i,
  input wire logic [31:0] io_base_i,
  input wire logic [31:0] io_limit_i,
  // primary transaction decode
  input wire logic [31:0] pri_addr_i,
  input wire logic pri_io_i,
  input wire logic pri_mem_i,
  output logic pri_claim_o,
  // secondary transaction decode
  input wire logic [31:0] sec_addr_i,
  input wire logic sec_io_i,
  input wire logic sec_mem_i,
  output logic sec_claim_o,
  // error events from the secondary interface
  input wire logic sec_data_perr_i,
  input wire logic sec_addr_perr_i,
  input wire logic sec_bridge_master_i,
  input wire logic sec_serr_n_i,
  output logic sec_perr_n_o,
  output logic sec_perr_oe_o,
  output logic dpar_reported_set_o,
  output logic pri_serr_n_o,
  output logic pri_serr_oe_o
);

  import bridge_cfg_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] subsys_id_ff;
  logic [BC_WIDTH-1:0] brg_ctl_ff;
  logic [31:0] rdata_ff;
  logic rvalid_ff;
  logic perr_drive_ff;
  logic dpar_set_ff;
  logic serr_drive_ff;
  logic [15:0] nxt_subsys_id;
  logic [BC_WIDTH-1:0] nxt_brg_ctl;
  logic [31:0] nxt_rdata;
  cfg_access_t access;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire logic [7:0] dword_addr = {cfg_addr_i[7:2], 2'b00};
  wire logic hit_cap = (dword_addr == CAP_DWORD_ADDR);
  wire logic hit_brg = (dword_addr == BRG_DWORD_ADDR);
  wire logic [3:0] be = ~cfg_byte_en_n_i;
  wire logic perr_resp = brg_ctl_ff[BC_PERR_RESP];
  wire logic serr_fwd = brg_ctl_ff[BC_SERR_FWD];
  wire logic isa_mode = brg_ctl_ff[BC_ISA_MODE];
  wire logic vga_mode = brg_ctl_ff[BC_VGA_MODE];

  // write wins over read if both are raised together
  assign access = cfg_write_i ? ACC_WRITE : (cfg_read_i ? ACC_READ : ACC_IDLE);

  // byte-lane merge; read-only bytes have no storage to touch
  assign nxt_subsys_id = {
    (hit_cap && be[3]) ? cfg_wdata_i[31:24] : subsys_id_ff[15:8],
    (hit_cap && be[2]) ? cfg_wdata_i[23:16] : subsys_id_ff[7:0]
  };
  assign nxt_brg_ctl = (hit_brg && be[2]) ? cfg_wdata_i[16 +: BC_WIDTH] : brg_ctl_ff;

  // read mux; unmapped dwords read as zero
  always_comb
  begin
    nxt_rdata = 32'h00000000;
    unique case (1'b1)
      hit_cap:
      begin
        nxt_rdata[7:0] = CAP_PTR_VALUE;
        nxt_rdata[15:8] = 8'h00;
        nxt_rdata[31:16] = subsys_id_ff;
      end
      hit_brg:
      begin
        nxt_rdata[15:8] = INT_PIN_VALUE;
        nxt_rdata[16 +: BC_WIDTH] = brg_ctl_ff;
      end
      default:
      begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  // configuration state
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      subsys_id_ff <= SUBSYS_RESET;
      brg_ctl_ff <= BRG_CTL_RESET;
    end
    else if (access == ACC_WRITE)
    begin
      subsys_id_ff <= nxt_subsys_id;
      brg_ctl_ff <= nxt_brg_ctl;
    end
  end

  // read data always come from a flop, one cycle after the request
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rdata_ff <= 32'h00000000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= (access == ACC_READ);
      if (access == ACC_READ)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign cfg_rdata_o = rdata_ff;
  assign cfg_rvalid_o = rvalid_ff;

  // ----------------------------------------------------------------
  // transaction decode
  // ----------------------------------------------------------------
  logic pri_in_win;
  logic pri_alias;
  logic pri_vga_io;
  logic pri_vga_mem;
  logic sec_in_win;
  logic sec_alias;
  logic sec_vga_io;
  logic sec_vga_mem;

  bridge_addr_decode pri_decode (
    .addr_i(pri_addr_i),
    .io_base_i(io_base_i),
    .io_limit_i(io_limit_i),
    .isa_mode_i(isa_mode),
    .vga_mode_i(vga_mode),
    .in_io_window_o(pri_in_win),
    .isa_alias_o(pri_alias),
    .vga_io_o(pri_vga_io),
    .vga_mem_o(pri_vga_mem)
  );

  bridge_addr_decode sec_decode (
    .addr_i(sec_addr_i),
    .io_base_i(io_base_i),
    .io_limit_i(io_limit_i),
    .isa_mode_i(isa_mode),
    .vga_mode_i(vga_mode),
    .in_io_window_o(sec_in_win),
    .isa_alias_o(sec_alias),
    .vga_io_o(sec_vga_io),
    .vga_mem_o(sec_vga_mem)
  );

  // isa alias drop only applies inside the first 64KB
  wire logic pri_low64k = (pri_addr_i[31:16] == IO_LOW64K_HI);
  wire logic pri_isa_drop = pri_alias && pri_low64k;
  // window forwarding; with isa off nothing is dropped
  wire logic pri_win_fwd = pri_in_win && !pri_isa_drop;
  // vga claims bypass the window and isa mode; enables gate them
  wire logic pri_io_claim = io_space_en_i && pri_io_i && (pri_win_fwd || pri_vga_io);
  wire logic pri_mem_claim = mem_space_en_i && pri_mem_i && pri_vga_mem;
  // upstream: outside window, or an isa alias address; never a vga range
  wire logic sec_io_fwd = sec_io_i && (!sec_in_win || sec_alias) && !sec_vga_io;
  wire logic sec_mem_fwd = sec_mem_i && !sec_vga_mem;

  // claims are combinational so the bus engine sees them in the address phase
  assign pri_claim_o = pri_io_claim || pri_mem_claim;
  assign sec_claim_o = sec_io_fwd || sec_mem_fwd;

  // ----------------------------------------------------------------
  // error reporting
  // ----------------------------------------------------------------
  wire logic nxt_perr_drive = perr_resp && sec_data_perr_i;
  // status set only for transfers this bridge mastered on the secondary side
  wire logic nxt_dpar_set = nxt_perr_drive && sec_bridge_master_i;
  wire logic addr_perr_serr = perr_resp && sec_addr_perr_i;
  wire logic fwd_serr = serr_fwd && !sec_serr_n_i;
  wire logic nxt_serr_drive = serr_drv_en_i && (addr_perr_serr || fwd_serr);

  // one-cycle registered drive; open-drain style outputs
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      perr_drive_ff <= 1'b0;
      dpar_set_ff <= 1'b0;
      serr_drive_ff <= 1'b0;
    end
    else
    begin
      perr_drive_ff <= nxt_perr_drive;
      dpar_set_ff <= nxt_dpar_set;
      serr_drive_ff <= nxt_serr_drive;
    end
  end

  assign sec_perr_n_o = !perr_drive_ff;
  assign sec_perr_oe_o = perr_drive_ff;
  assign dpar_reported_set_o = dpar_set_ff;
  assign pri_serr_n_o = !serr_drive_ff;
  assign pri_serr_oe_o = serr_drive_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  a_cap_ptr_read: assert property (cfg_read_i && !cfg_write_i && hit_cap |=>
    cfg_rvalid_o && cfg_rdata_o[7:0] == 8'hdc) else $error("pointer not dch");
  a_cap_reserved_zero: assert property (cfg_read_i && !cfg_write_i && hit_cap |=>
    cfg_rdata_o[15:8] == 8'h00) else $error("reserved bits not zero");
  a_subsys_write: assert property (cfg_write_i && hit_cap && be[3] |=>
    subsys_id_ff[15:8] == $past(cfg_wdata_i[31:24])) else $error("subsystem_identifier lost write");
  a_int_pin_zero: assert property (cfg_read_i && !cfg_write_i && hit_brg |=>
    cfg_rdata_o[15:8] == 8'h00) else $error("interrupt pin not zero");
  a_perr_blocked: assert property (!perr_resp |=>
    !sec_perr_oe_o && !dpar_reported_set_o) else $error("perr while response off");
  a_perr_driven: assert property (perr_resp && sec_data_perr_i |=>
    sec_perr_oe_o && !sec_perr_n_o) else $error("perr not driven");
  a_addr_perr_serr: assert property (sec_addr_perr_i && !perr_resp && !fwd_serr |=>
    !pri_serr_oe_o) else $error("serr without parity response");
  a_serr_no_fwd: assert property (!serr_fwd && !sec_addr_perr_i |=>
    !pri_serr_oe_o) else $error("serr forwarded while disabled");
  a_serr_fwd: assert property (serr_fwd && serr_drv_en_i && !sec_serr_n_i |=>
    pri_serr_oe_o) else $error("serr not forwarded");
  a_isa_off_window: assert property (!isa_mode && !vga_mode && io_space_en_i && pri_io_i
    |-> pri_claim_o == pri_in_win) else $error("window not forwarded");
  a_isa_alias_drop: assert property (isa_mode && !vga_mode && pri_io_i && !pri_mem_i
    && pri_low64k && pri_addr_i[9:8] != 2'h0 |-> !pri_claim_o) else $error("alias claimed");
  a_isa_up: assert property (isa_mode && sec_io_i && !sec_vga_io && sec_addr_i[9:8] != 2'h0
    |-> sec_claim_o) else $error("alias not forwarded up");
  a_vga_mem: assert property (vga_mode && mem_space_en_i && pri_mem_i
    && pri_addr_i >= 32'h000a0000 && pri_addr_i <= 32'h000bffff |-> pri_claim_o)
    else $error("vga memory not claimed");
  a_vga_io: assert property (vga_mode && io_space_en_i && pri_io_i && pri_addr_i[31:16] == 16'h0
    && pri_addr_i[9:0] >= 10'h3c0 && pri_addr_i[9:0] <= 10'h3df |-> pri_claim_o)
    else $error("vga io not claimed");
  a_vga_sec_ignore: assert property (vga_mode && !sec_io_i && sec_mem_i
    && sec_addr_i >= 32'h000a0000 && sec_addr_i <= 32'h000bffff |-> !sec_claim_o)
    else $error("vga memory forwarded up");
  a_ro_bytes: assert property (cfg_write_i && hit_cap && !be[3] && !be[2] |=>
    $stable(subsys_id_ff)) else $error("disabled lanes written");
  a_dpar_master: assert property (perr_resp && sec_data_perr_i |=>
    dpar_reported_set_o == $past(sec_bridge_master_i)) else $error("status set wrongly");
  a_vga_off_ignore: assert property (!vga_mode && pri_io_i && !pri_mem_i && !pri_in_win
    |-> !pri_claim_o) else $error("io outside window claimed");
  a_vga_io_mono: assert property (vga_mode && io_space_en_i && pri_io_i
    && pri_addr_i[31:16] == 16'h0 && pri_addr_i[9:0] >= 10'h3b0 && pri_addr_i[9:0] <= 10'h3bb
    |-> pri_claim_o) else $error("vga mono io not claimed");

  c_serr_forward: cover property (serr_fwd && !sec_serr_n_i ##1 pri_serr_oe_o);
  c_perr_report: cover property (sec_data_perr_i && perr_resp ##1 dpar_reported_set_o);
  c_vga_claim: cover property (vga_mode && pri_io_i && pri_claim_o && !pri_in_win);
  c_cfg_readback: cover property (cfg_write_i && hit_brg ##1 cfg_read_i && hit_brg);
  c_isa_alias_up: cover property (isa_mode && sec_io_i && sec_alias && sec_claim_o);

endmodule
